// *** design/wdrc_pkg.sv ***
// watchdog with reset-cause flags: shared constants
// assumes an 8-bit data-space register port on the system clock
package wdrc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] WDRC_CTRL_ADDR = 8'h60;
	localparam logic [7:0] WDRC_CAUSE_ADDR = 8'h5c;

	// ------------------------------------------------------------
	// watchdog_control fields
	// ------------------------------------------------------------
	localparam int WDRC_IRQ_FLAG_BIT = 7;
	localparam int WDRC_IRQ_EN_BIT = 6;
	localparam int WDRC_PERIOD_HI_BIT = 5;
	localparam int WDRC_UNLOCK_BIT = 4;
	localparam int WDRC_SRE_BIT = 3;
	localparam int WDRC_PERIOD_LO_MSB = 2;

	// ------------------------------------------------------------
	// reset_cause_status fields
	// ------------------------------------------------------------
	localparam int WDRC_SCAN_BIT = 4;
	localparam int WDRC_WDT_BIT = 3;
	localparam int WDRC_BOR_BIT = 2;
	localparam int WDRC_PIN_BIT = 1;
	localparam int WDRC_POR_BIT = 0;
	localparam logic [4:0] WDRC_CAUSE_POR_VALUE = 5'h01;

	// ------------------------------------------------------------
	// timing and counter
	// ------------------------------------------------------------
	localparam logic [1:0] WDRC_UNLOCK_LAST = 2'h3;
	localparam int WDRC_CNT_W = 21;
	localparam int WDRC_BASE_CYCLES = 2048;
	localparam logic [3:0] WDRC_PERIOD_MAX = 4'h9;
	localparam int WDRC_NSYNC = 5;
endpackage

// *** design/wdrc_top.sv ***
// watchdog timer with reset-cause recording, one system clock
// assumes rst_n_i is the power-on reset; other reset sources arrive as levels
//
// Behaviour
// - scan reset sets bit4; POR or zero clears
// - watchdog reset sets bit3; POR or zero clears
// - brown-out reset sets bit2; POR or zero clears
// - pin reset sets bit1; POR or zero clears
// - POR sets bit0; only write zero clears
// - timeout in interrupt mode sets flag bit7
// - irq only when global and watchdog enable
// - combined mode: vector clears enable and flag
// - combined mode: unserviced second timeout resets system
// - fuse and enables select the mode
// - unlock bit self clears after four cycles
// - reset-enable clear, period change need unlock
// - watchdog reset flag holds reset enable high
// - period is 2048 shifted by code; codes above 9 act as 9
// - programmed fuse locks enable one, irq zero
// - counter counts oscillator cycles, restart zeroes it
`timescale 1ns/1ns
`default_nettype none
module wdrc_top #(
	parameter int BASE_CYCLES = wdrc_pkg::WDRC_BASE_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wdt_osc_i,
	input wire logic wdr_i,
	input wire logic irq_ack_i,
	input wire logic global_irq_en_i,
	input wire logic forced_on_fuse_i,
	input wire logic pin_reset_i,
	input wire logic brownout_reset_i,
	input wire logic scan_reset_i,
	output logic [7:0] rd_data_o,
	output logic irq_o,
	output logic sys_reset_o
);
	import wdrc_pkg::*;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [WDRC_NSYNC-1:0] meta;
	logic [WDRC_NSYNC-1:0] sync;
	logic osc_prev;
	wire [WDRC_NSYNC-1:0] async_in = {wdt_osc_i, scan_reset_i, brownout_reset_i, pin_reset_i, forced_on_fuse_i};

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			sync <= '0;
			osc_prev <= 1'b0;
		end else begin
			meta <= async_in;
			sync <= meta;
			osc_prev <= sync[4];
		end
	end

	wire osc_tick = sync[4] & ~osc_prev;
	wire scan_rst = sync[3];
	wire bor_rst = sync[2];
	wire pin_rst = sync[1];
	wire fuse_prog = ~sync[0];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic irq_flag;
	logic irq_en;
	logic [3:0] period;
	logic unlock;
	logic [1:0] unlock_cnt;
	logic sre;
	logic [4:0] cause;
	logic [WDRC_CNT_W-1:0] count;

	// ------------------------------------------------------------
	// decode and mode
	// ------------------------------------------------------------
	wire ctrl_wr = wr_i & (addr_i == WDRC_CTRL_ADDR);
	wire cause_wr = wr_i & (addr_i == WDRC_CAUSE_ADDR);
	wire unlock_wr = ctrl_wr & wdata_i[WDRC_UNLOCK_BIT] & wdata_i[WDRC_SRE_BIT];
	wire ext_rst = scan_rst | bor_rst | pin_rst;
	wire ctrl_clr = ext_rst | sys_reset_o;
	wire eff_sre = sre | fuse_prog;
	wire eff_ie = irq_en & ~fuse_prog;
	wire running = eff_sre | eff_ie;
	wire [3:0] code_eff = (period > WDRC_PERIOD_MAX) ? WDRC_PERIOD_MAX : period;
	wire [WDRC_CNT_W-1:0] limit = WDRC_CNT_W'(BASE_CYCLES) << code_eff;
	wire tmo = running & osc_tick & (count >= limit - 1'b1);
	wire reset_now = tmo & eff_sre & (~eff_ie | irq_flag);
	wire set_flag = tmo & eff_ie;
	wire ack_combined = irq_ack_i & eff_sre;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	wire next_unlock = ctrl_clr ? 1'b0 :
		unlock_wr ? 1'b1 :
		ctrl_wr ? 1'b0 :
		(unlock && unlock_cnt == WDRC_UNLOCK_LAST) ? 1'b0 : unlock;
	wire [1:0] next_unlock_cnt = (unlock_wr || !unlock) ? 2'h0 : unlock_cnt + 2'h1;
	wire sre_wr = wdata_i[WDRC_SRE_BIT] | (~unlock & sre);
	wire next_sre = (ctrl_clr ? 1'b0 : ctrl_wr ? sre_wr : sre)
		| cause[WDRC_WDT_BIT] | fuse_prog;
	wire [3:0] next_period = ctrl_clr ? 4'h0 :
		(ctrl_wr && unlock) ? {wdata_i[WDRC_PERIOD_HI_BIT], wdata_i[WDRC_PERIOD_LO_MSB:0]} : period;
	wire next_irq_en = ~fuse_prog & ~ctrl_clr & ~ack_combined
		& (ctrl_wr ? wdata_i[WDRC_IRQ_EN_BIT] : irq_en);
	wire flag_clr = ctrl_clr | irq_ack_i | (ctrl_wr & wdata_i[WDRC_IRQ_FLAG_BIT]);
	wire next_irq_flag = set_flag | (irq_flag & ~flag_clr);
	wire [4:0] cause_set = {scan_rst, reset_now, bor_rst, pin_rst, 1'b0};
	wire [4:0] cause_keep = cause_wr ? wdata_i[4:0] : 5'h1f;
	wire [4:0] next_cause = cause_set | (cause & cause_keep);
	wire [WDRC_CNT_W-1:0] next_count = (ctrl_clr || wdr_i || !running || tmo) ? '0 :
		osc_tick ? count + 1'b1 : count;
	wire [7:0] ctrl_rd = {irq_flag, irq_en, period[3], unlock, sre, period[2:0]};
	wire [7:0] next_rd_data = (addr_i == WDRC_CTRL_ADDR) ? ctrl_rd :
		(addr_i == WDRC_CAUSE_ADDR) ? {3'h0, cause} : 8'h00;
	wire next_irq = next_irq_flag & next_irq_en & global_irq_en_i;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unlock <= 1'b0;
			unlock_cnt <= 2'h0;
			sre <= 1'b0;
			period <= 4'h0;
			irq_en <= 1'b0;
			irq_flag <= 1'b0;
			cause <= WDRC_CAUSE_POR_VALUE;
			count <= '0;
		end else begin
			unlock <= next_unlock;
			unlock_cnt <= next_unlock_cnt;
			sre <= next_sre;
			period <= next_period;
			irq_en <= next_irq_en;
			irq_flag <= next_irq_flag;
			cause <= next_cause;
			count <= next_count;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 8'h00;
			irq_o <= 1'b0;
			sys_reset_o <= 1'b0;
		end else begin
			rd_data_o <= next_rd_data;
			irq_o <= next_irq;
			sys_reset_o <= reset_now;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_unlock_quiet;
		$rose(unlock) ##1 (!ctrl_wr && !ctrl_clr) [*3];
	endsequence

	sequence s_first_timeout;
		tmo && eff_ie && eff_sre && !irq_flag && !irq_ack_i && !ctrl_clr;
	endsequence

	a_unlock_expire: assert property (s_unlock_quiet |=> !unlock)
		else $error("unlock bit did not clear after four cycles");

	a_sre_clear_lock: assert property ($fell(sre) |-> $past(unlock) || $past(ctrl_clr))
		else $error("reset enable cleared while locked");

	a_period_lock: assert property ($changed(period) |-> $past(unlock) || $past(ctrl_clr))
		else $error("period changed while locked");

	a_watchdog_reset_flag_holds_sre: assert property (cause[WDRC_WDT_BIT] |=> sre)
		else $error("reset enable low while watchdog flag set");

	a_por_sticky: assert property ($fell(cause[WDRC_POR_BIT]) |-> $past(cause_wr && !wdata_i[0]))
		else $error("power-on flag cleared without software write");

	a_wdt_flag_set: assert property (sys_reset_o |-> cause[WDRC_WDT_BIT] ##1 sre)
		else $error("watchdog reset did not set flag and enable");

	a_irq_gate: assert property (irq_o |-> $past(global_irq_en_i) && irq_flag && irq_en)
		else $error("interrupt raised without enables");

	a_combined_steps: assert property (s_first_timeout |=> irq_flag && !sys_reset_o)
		else $error("first combined timeout did not set flag only");

	a_combined_reset: assert property (tmo && eff_ie && eff_sre && irq_flag |=> sys_reset_o)
		else $error("unserviced combined timeout did not reset");

	a_ack_clears: assert property (irq_ack_i && eff_sre && !tmo |=> !irq_en && !irq_flag)
		else $error("vector did not clear enable and flag");

	a_fuse_lock: assert property (fuse_prog |=> sre && !irq_en)
		else $error("fuse lock not applied");

	a_restart_zero: assert property (wdr_i |=> count == '0)
		else $error("restart did not zero counter");

endmodule // wdrc_top
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the watchdog with reset-cause flags
// assumes wdrc_top built with BASE_CYCLES 4 and assertions inside it
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; \
	$display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module testbench;
import wdrc_pkg::*;
logic clock_i = 0, rst_n_i = 0, wr_i = 0, wdt_osc_i = 0, wdr_i = 0, irq_ack_i = 0, gie = 1, fuse = 1;
logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rd, rdv;
logic [2:0] src = 3'h0;
logic irq_o, sys_reset_o;
int miscompares = 0, checks_done = 0, oc = 0, n, resets = 0;
wdrc_top #(.BASE_CYCLES(4)) u_wdrc_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
	.wdata_i(wdata_i), .wdt_osc_i(wdt_osc_i), .wdr_i(wdr_i), .irq_ack_i(irq_ack_i), .global_irq_en_i(gie),
	.forced_on_fuse_i(fuse), .pin_reset_i(src[0]), .brownout_reset_i(src[1]), .scan_reset_i(src[2]),
	.rd_data_o(rd), .irq_o(irq_o), .sys_reset_o(sys_reset_o));
// ------------------------------------------------------------
// clock, oscillator, helpers
// ------------------------------------------------------------
initial begin
	forever #5 clock_i = ~clock_i;
end
always @(posedge clock_i) begin
	oc <= (oc + 1) % 5;
	if (oc == 4) wdt_osc_i <= ~wdt_osc_i;
	if (sys_reset_o === 1'b1) resets <= resets + 1;
end
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clock_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
	@(posedge clock_i); wr_i <= 1'b0;
endtask
task automatic rdr(input logic [7:0] a);
	@(posedge clock_i); addr_i <= a;
	@(posedge clock_i); @(negedge clock_i); rdv = rd;
endtask
task automatic ctl(input logic [7:0] d);
	wr(WDRC_CTRL_ADDR, 8'h18); wr(WDRC_CTRL_ADDR, d);
endtask
task automatic kick(input bit ack);
	@(posedge clock_i); if (ack) irq_ack_i <= 1'b1; else wdr_i <= 1'b1;
	@(posedge clock_i); irq_ack_i <= 1'b0; wdr_i <= 1'b0;
endtask
task automatic wait_sig(input bit sel, input int lim);
	n = 0;
	do begin @(posedge clock_i); #1; n++; end while (((sel ? sys_reset_o : irq_o) !== 1'b1) && n < lim);
endtask
task automatic conclude;
	$display("checks %0d mismatches %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task automatic t_unlock;
	rdr(WDRC_CAUSE_ADDR); `CHK("cause after por", 8'h01, rdv)
	wr(WDRC_CTRL_ADDR, 8'h08); wr(WDRC_CTRL_ADDR, 8'h00); rdr(WDRC_CTRL_ADDR);
	`CHK("locked clear", 8'h08, rdv)
	wr(WDRC_CTRL_ADDR, 8'h18); repeat (5) @(posedge clock_i); wr(WDRC_CTRL_ADDR, 8'h00); rdr(WDRC_CTRL_ADDR);
	`CHK("expired unlock", 8'h08, rdv)
	ctl(8'h00); rdr(WDRC_CTRL_ADDR); `CHK("unlocked clear", 8'h00, rdv)
	$display("unlock test done");
endtask
task automatic t_irq;
	for (int c = 0; c < 2; c++) begin
		kick(0); ctl(8'hc0 | 8'(c)); kick(0); wait_sig(0, 200);
		`CHK("irq latency", 1'b1, n >= (40 << c) - 10 && n <= (40 << c) + 20)
	end
	rdr(WDRC_CTRL_ADDR); `CHK("irq flag", 1'b1, rdv[WDRC_IRQ_FLAG_BIT])
	@(posedge clock_i); gie <= 1'b0;
	repeat (2) @(posedge clock_i); #1; `CHK("irq masked", 1'b0, irq_o)
	@(posedge clock_i); gie <= 1'b1;
	kick(1); rdr(WDRC_CTRL_ADDR); `CHK("flag after ack", 1'b0, rdv[WDRC_IRQ_FLAG_BIT])
	$display("interrupt test done");
endtask
task automatic t_comb;
	kick(0);
	ctl(8'hc8); kick(0); wait_sig(0, 200); `CHK("first timeout irq", 1'b1, irq_o)
	wait_sig(1, 100); `CHK("second timeout reset", 1'b1, sys_reset_o)
	kick(0); rdr(WDRC_CAUSE_ADDR); `CHK("cause wdt", 8'h09, rdv)
	rdr(WDRC_CTRL_ADDR); `CHK("ctrl after wdt", 8'h08, rdv)
	ctl(8'h48); kick(0); wait_sig(0, 200); kick(1); rdr(WDRC_CTRL_ADDR);
	`CHK("vector clears", 8'h08, rdv)
	kick(0); ctl(8'h00); rdr(WDRC_CTRL_ADDR); `CHK("sre held", 8'h08, rdv)
	kick(0); wr(WDRC_CAUSE_ADDR, 8'h00); rdr(WDRC_CAUSE_ADDR); `CHK("cause cleared", 8'h00, rdv)
	ctl(8'h00); rdr(WDRC_CTRL_ADDR); `CHK("sre released", 8'h00, rdv)
	$display("combined test done");
endtask
task automatic t_src;
	for (int i = 0; i < 3; i++) begin
		@(posedge clock_i); src <= 3'(1 << i); repeat (4) @(posedge clock_i); src <= 3'h0;
		repeat (4) @(posedge clock_i); rdr(WDRC_CAUSE_ADDR);
		`CHK("cause source", (i == 2) ? 8'h10 : 8'(8'h02 << i), rdv)
		wr(WDRC_CAUSE_ADDR, 8'h00);
	end
	n = resets;
	repeat (60) @(posedge clock_i);
	`CHK("stopped mode", n, resets)
	$display("source test done");
endtask
task automatic t_fuse;
	fuse <= 1'b0; repeat (4) @(posedge clock_i); wr(WDRC_CTRL_ADDR, 8'h40); rdr(WDRC_CTRL_ADDR);
	`CHK("fuse lock", 8'h08, rdv & 8'h48)
	n = resets;
	repeat (10) begin kick(0); repeat (20) @(posedge clock_i); end
	`CHK("restart holds off", n, resets)
	wait_sig(1, 100); `CHK("fuse reset mode", 1'b1, sys_reset_o)
	$display("fuse test done");
endtask
initial begin
	repeat (8) @(posedge clock_i);
	rst_n_i <= 1'b1;
	repeat (3) @(posedge clock_i);
	t_unlock; t_irq; t_comb; t_src; t_fuse;
	conclude;
end
initial begin
	#200000;
	miscompares++;
	conclude;
end
endmodule // testbench
`default_nettype wire
